// file: emb_pkg.sv
// shared constants and types of the external memory bus interface
package emb_pkg;

  // apb register indices; byte address is four times the index
  localparam logic [9:0] IDX_PAGE = 10'h092;
  localparam logic [9:0] IDX_CFG  = 10'h0A0;
  localparam logic [9:0] IDX_STAT = 10'h0A1;

  // configuration word field positions
  localparam int CFG_HIGH_GPIO_BIT = 0;
  localparam int CFG_LOW_GPIO_BIT  = 1;
  localparam int CFG_BOOT_EN_BIT   = 2;

  // status word field positions
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_EXT_BIT  = 2;
  localparam int STAT_BUSY_BIT = 3;

  // reset values
  localparam logic [7:0] CFG_RESET  = 8'h07;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // program and data address map
  localparam logic [15:0] FIRST_FETCH_ADDR = 16'h0000;
  localparam logic [15:0] BOOT_USER_BASE   = 16'hF800;
  localparam logic [15:0] BOOT_PROG_TOP    = 16'h0800;
  localparam int          INT_PROG_KB_DEF  = 32;
  localparam int          INT_DATA_B_DEF   = 1024;

  // read or write strobe length in clock cycles
  localparam int STROBE_CYCLES_DEF = 2;

  // operating mode, coded as {program strobe pin, latch strobe pin} at reset
  typedef enum logic [1:0] {
    MODE_RSVD     = 2'b00,
    MODE_SERIAL   = 2'b01,
    MODE_PARALLEL = 2'b10,
    MODE_USER     = 2'b11
  } emb_mode_e;

  // kind of request from the core
  typedef enum logic [1:0] {
    KIND_FETCH = 2'b00,
    KIND_READ  = 2'b01,
    KIND_WRITE = 2'b10
  } emb_kind_e;

  // bus cycle sequencer states
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_ALE   = 6'b000010,
    S_ADR   = 6'b000100,
    S_SETUP = 6'b001000,
    S_STRB  = 6'b010000,
    S_HOLD  = 6'b100000
  } emb_fsm_e;

endpackage

// file: emb_ext_bus.sv
// external memory bus sequencer with apb configuration registers
`timescale 1ns/1ps

// Summary of operation
// - first fetch after any reset is taken from address 0000h
// - strap high: fetches beyond internal program size and outside boot rom go external, others internal
// - strap low at reset: every fetch goes external
// - internal program size is a 4k/8k/16k/32k parameter bounding internal fetches
// - user mode with boot rom enabled: boot rom answers F800h to FFFFh
// - programming mode: boot rom occupies lowest 2kB of program space
// - both port bits cleared: every address, internal or external, appears on ports
// - data phase of internal cycles shows zero on low port
// - external program reads use program read strobe only
// - external data reads and writes use the read and write strobes
// - fetches use 16-bit address; data moves use 16-bit or 8-bit address
// - 8-bit data moves keep page byte on high port all cycle
// - low port carries address low byte, then data byte
// - bus pins are driven push-pull in bus mode
// - address low byte is valid at falling edge of latch strobe
// - write data stands before write strobe and until after its release
// - read data is sampled just before the read strobe is released
// - access with ports in gpio mode leaves port values unchanged
// - port function bits change only in programming mode; default gpio
// - external fetch drives program counter high byte on high port
// - high port in bus use forces the strobe pins to strobe duty
// - strobe pins sampled at reset select serial, parallel, user or reserved mode
// - any reset leaves programming mode and selects the mode again
// - low port bit cleared: low port serves bus, strobes on port 3 pins
// - high port bit cleared: high port serves bus when low port bit is cleared too; set gives gpio
module emb_ext_bus
#(
  parameter int INT_PROG_KB   = emb_pkg::INT_PROG_KB_DEF,
  parameter int INT_DATA_B    = emb_pkg::INT_DATA_B_DEF,
  parameter int STROBE_CYCLES = emb_pkg::STROBE_CYCLES_DEF
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              req_valid,
  input  wire emb_pkg::emb_kind_e req_kind,
  input  wire logic              req_short,
  input  wire logic [15:0]       req_addr,
  input  wire logic [7:0]        req_wdata,
  output logic                   req_ready,
  output logic                   resp_valid,
  output logic      [7:0]        resp_rdata,
  output logic                   resp_external,
  input  wire logic [7:0]        int_rdata,
  input  wire logic              external_fetch_select_n,
  input  wire logic [7:0]        low_bus_port_in,
  output logic      [7:0]        low_bus_port_out,
  output logic                   low_bus_port_oe,
  output logic      [7:0]        high_bus_port_out,
  output logic                   high_bus_port_oe,
  input  wire logic              ale_in,
  output logic                   ale_out,
  output logic                   ale_oe,
  input  wire logic              program_read_strobe_n_in,
  output logic                   program_read_strobe_n_out,
  output logic                   program_read_strobe_n_oe,
  output logic                   write_strobe_n,
  output logic                   read_strobe_n,
  output logic                   strobe_oe
);
  import emb_pkg::*;

  localparam logic [16:0] INT_PROG_TOP = 17'(INT_PROG_KB * 1024);
  localparam logic [16:0] INT_DATA_TOP = 17'(INT_DATA_B);
  localparam logic [2:0]  STRB_LOAD    = 3'(STROBE_CYCLES);

  typedef struct packed {
    emb_fsm_e    fsm;
    logic [2:0]  cnt;
    logic        sampled;
    emb_mode_e   mode;
    logic        ea_ext;
    logic        first_fetch;
    logic [7:0]  cfg;
    logic [7:0]  page;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        req_ready;
    logic        resp_valid;
    logic [7:0]  resp_rdata;
    logic        resp_external;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        is_write;
    logic        is_fetch;
    logic        is_short;
    logic        is_ext;
    logic [7:0]  low_out;
    logic        low_oe;
    logic [7:0]  high_out;
    logic        high_oe;
    logic        ale;
    logic        pin_oe;
    logic        prog_n;
    logic        wr_n;
    logic        rd_n;
    logic        strobe_oe;
  } emb_state_s;

  localparam emb_state_s ST_RESET = '{
    fsm: S_IDLE, mode: MODE_USER, first_fetch: 1'b1, cfg: CFG_RESET, page: PAGE_RESET,
    prog_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, ale: 1'b0, default: '0};

  emb_state_s st;
  emb_state_s next_st;
  logic       low_en;
  logic       high_en;
  logic       prog_mode;
  logic       accept;
  logic [15:0] a_use;
  logic       route_ext;
  logic       boot_hit;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the current configuration and request routing

  // ports serve the bus only while their gpio bits are cleared
  assign low_en    = ~st.cfg[CFG_LOW_GPIO_BIT];
  assign high_en   = ~st.cfg[CFG_HIGH_GPIO_BIT];
  assign prog_mode = (st.mode == MODE_SERIAL) || (st.mode == MODE_PARALLEL);
  assign accept    = req_valid & st.req_ready;

  // the very first fetch is forced to the reset vector
  assign a_use = (st.first_fetch && req_kind == KIND_FETCH) ? FIRST_FETCH_ADDR
                                                             : req_addr;

  // fetch and data targets; boot rom wins over flash below the strap override
  always_comb
  begin
    boot_hit  = 1'b0;
    route_ext = 1'b0;
    if (req_kind == KIND_FETCH)
    begin
      if (prog_mode)
        boot_hit = (a_use < BOOT_PROG_TOP);
      else
        boot_hit = st.cfg[CFG_BOOT_EN_BIT] && (a_use >= BOOT_USER_BASE);
      if (st.ea_ext)
        route_ext = 1'b1;
      else if (boot_hit)
        route_ext = 1'b0;
      else
        route_ext = ({1'b0, a_use} >= INT_PROG_TOP);
    end
    else
      route_ext = ({1'b0, a_use} >= INT_DATA_TOP);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole block

  always_comb
  begin
    next_st            = st;
    next_st.resp_valid = 1'b0;
    next_st.pready     = 1'b0;
    next_st.pslverr    = 1'b0;

    // mode straps are read in the first cycle after any reset release;
    // pins stay undriven until then so the straps are visible
    if (!st.sampled)
    begin
      next_st.sampled   = 1'b1;
      next_st.mode      = emb_mode_e'({program_read_strobe_n_in, ale_in});
      next_st.ea_ext    = ~external_fetch_select_n;
      next_st.pin_oe    = 1'b1;
      next_st.req_ready = 1'b1;
    end

    // strobe pins belong to the bus while either port serves it
    next_st.strobe_oe = low_en | high_en;

    // apb: answer in the second access cycle, write takes effect with it
    if (psel && penable && !st.pready)
    begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0000_0000;
      case (paddr[11:2])
        IDX_PAGE: next_st.prdata[7:0] = st.page;
        IDX_CFG:  next_st.prdata[7:0] = st.cfg;
        IDX_STAT:
        begin
          next_st.prdata[STAT_MODE_LSB +: 2] = st.mode;
          next_st.prdata[STAT_EXT_BIT]       = st.ea_ext;
          next_st.prdata[STAT_BUSY_BIT]      = (st.fsm != S_IDLE);
        end
        default:  next_st.pslverr = 1'b1;
      endcase
      if (pwrite && paddr[11:2] == IDX_STAT)
        next_st.pslverr = 1'b1;
    end

    // writes land on the edge where the master sees pready, not before
    if (psel && penable && st.pready && pwrite)
    begin
      if (paddr[11:2] == IDX_PAGE)
        next_st.page = pwdata[7:0];
      // port function bits are locked outside programming mode
      if (paddr[11:2] == IDX_CFG && prog_mode)
        next_st.cfg = {5'h00, pwdata[2:0]};
    end

    // a port handed back to gpio stops being driven by the bus
    if (!low_en)
      next_st.low_oe = 1'b0;
    if (!high_en)
      next_st.high_oe = 1'b0;

    // bus cycle sequencer
    case (st.fsm)
      S_IDLE:
      begin
        if (accept)
        begin
          next_st.req_ready = 1'b0;
          next_st.addr      = a_use;
          next_st.wdata     = req_wdata;
          next_st.is_write  = (req_kind == KIND_WRITE);
          next_st.is_fetch  = (req_kind == KIND_FETCH);
          next_st.is_short  = req_short && (req_kind != KIND_FETCH);
          next_st.is_ext    = route_ext;
          if (req_kind == KIND_FETCH)
            next_st.first_fetch = 1'b0;
          if (low_en)
          begin
            // every address shows on the ports, internal or not
            next_st.fsm     = S_ALE;
            next_st.ale     = 1'b1;
            next_st.low_out = a_use[7:0];
            next_st.low_oe  = 1'b1;
            if (high_en)
            begin
              next_st.high_out = (req_short && req_kind != KIND_FETCH) ? st.page
                                                                       : a_use[15:8];
              next_st.high_oe  = 1'b1;
            end
          end
          else
          begin
            // ports in gpio use: pins untouched, answer at once
            next_st.resp_valid    = 1'b1;
            next_st.resp_external = route_ext;
            next_st.resp_rdata    = route_ext ? 8'hFF : int_rdata;
            next_st.req_ready     = 1'b1;
          end
        end
      end
      S_ALE:
      begin
        // address stays on the low port across the falling latch edge
        next_st.ale = 1'b0;
        next_st.fsm = S_ADR;
      end
      S_ADR:
      begin
        next_st.fsm = S_SETUP;
        if (!st.is_ext)
        begin
          next_st.low_out = 8'h00;
          next_st.low_oe  = 1'b1;
        end
        else if (st.is_write)
        begin
          next_st.low_out = st.wdata;
          next_st.low_oe  = 1'b1;
        end
        else
          next_st.low_oe = 1'b0;
      end
      S_SETUP:
      begin
        next_st.fsm = S_STRB;
        next_st.cnt = STRB_LOAD;
        // only external cycles wake the outside memory
        if (st.is_ext)
        begin
          next_st.prog_n = ~st.is_fetch;
          next_st.rd_n   = ~(~st.is_fetch & ~st.is_write);
          next_st.wr_n   = ~st.is_write;
        end
      end
      S_STRB:
      begin
        next_st.cnt = st.cnt - 3'd1;
        if (st.cnt <= 3'd1)
        begin
          next_st.fsm    = S_HOLD;
          next_st.prog_n = 1'b1;
          next_st.rd_n   = 1'b1;
          next_st.wr_n   = 1'b1;
          // sampled on the edge that releases the strobe
          next_st.resp_rdata = st.is_ext ? low_bus_port_in : int_rdata;
        end
      end
      S_HOLD:
      begin
        // write data is still held one cycle after the strobe rises
        next_st.fsm           = S_IDLE;
        next_st.resp_valid    = 1'b1;
        next_st.resp_external = st.is_ext;
        next_st.req_ready     = 1'b1;
        if (st.is_write)
          next_st.resp_rdata = 8'h00;
      end
      default:
      begin
        next_st.fsm       = S_IDLE;
        next_st.req_ready = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset restarts mode selection as well

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= ST_RESET;
    else
      st <= next_st;
  end

  // all outputs are fields of the state register
  assign prdata                    = st.prdata;
  assign pready                    = st.pready;
  assign pslverr                   = st.pslverr;
  assign req_ready                 = st.req_ready;
  assign resp_valid                = st.resp_valid;
  assign resp_rdata                = st.resp_rdata;
  assign resp_external             = st.resp_external;
  assign low_bus_port_out          = st.low_out;
  assign low_bus_port_oe           = st.low_oe;
  assign high_bus_port_out         = st.high_out;
  assign high_bus_port_oe          = st.high_oe;
  assign ale_out                   = st.ale;
  assign ale_oe                    = st.pin_oe;
  assign program_read_strobe_n_out = st.prog_n;
  assign program_read_strobe_n_oe  = st.pin_oe;
  assign write_strobe_n            = st.wr_n;
  assign read_strobe_n             = st.rd_n;
  assign strobe_oe                 = st.strobe_oe;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_latch_pulse;
    ale_out ##1 !ale_out ##1 (!ale_out && st.fsm == S_SETUP);
  endsequence

  sequence s_bus_accept;
    st.fsm == S_IDLE && accept && low_en;
  endsequence

  property p_first_fetch;
    (st.fsm == S_IDLE && accept && st.first_fetch && req_kind == KIND_FETCH)
      |=> st.addr == 16'h0000;
  endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("first fetch not at 0000h");

  property p_strap_ext;
    (st.fsm == S_IDLE && accept && st.ea_ext && req_kind == KIND_FETCH) |=> st.is_ext;
  endproperty
  a_strap_ext: assert property (p_strap_ext) else $error("strap low fetch kept internal");

  property p_boot_user;
    (st.fsm == S_IDLE && accept && !st.ea_ext && st.mode == MODE_USER
     && st.cfg[CFG_BOOT_EN_BIT] && req_kind == KIND_FETCH && a_use >= 16'hF800)
      |=> !st.is_ext;
  endproperty
  a_boot_user: assert property (p_boot_user) else $error("boot rom fetch went external");

  property p_prog_strobe_only;
    !program_read_strobe_n_out |-> (st.is_fetch && read_strobe_n && write_strobe_n);
  endproperty
  a_prog_strobe_only: assert property (p_prog_strobe_only) else $error("wrong fetch strobe");

  property p_page_hold;
    (st.fsm != S_IDLE && st.is_short && high_bus_port_oe) |-> high_bus_port_out == st.page;
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page byte not on high port");

  property p_addr_at_fall;
    $fell(ale_out) |-> (low_bus_port_oe && low_bus_port_out == st.addr[7:0]);
  endproperty
  a_addr_at_fall: assert property (p_addr_at_fall) else $error("address invalid at latch fall");

  property p_write_data;
    (!write_strobe_n || $rose(write_strobe_n)) |-> (low_bus_port_oe && low_bus_port_out == st.wdata);
  endproperty
  a_write_data: assert property (p_write_data) else $error("write data not held");

  property p_internal_zero;
    (st.fsm == S_STRB && !st.is_ext) |-> (low_bus_port_oe && low_bus_port_out == 8'h00);
  endproperty
  a_internal_zero: assert property (p_internal_zero) else $error("internal data exposed");

  property p_gpio_quiet;
    st.cfg[CFG_LOW_GPIO_BIT] |-> (!low_bus_port_oe && !ale_out);
  endproperty
  a_gpio_quiet: assert property (p_gpio_quiet) else $error("gpio port driven by bus");

  property p_cfg_lock;
    $changed(st.cfg) |-> $past(prog_mode);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("port config changed in user mode");

  property p_latch_first;
    s_bus_accept |=> s_latch_pulse;
  endproperty
  a_latch_first: assert property (p_latch_first) else $error("latch pulse missing");

endmodule

// file: emb_mem_model.sv
// behavioural external memory with its address latch, far side of the bus
`timescale 1ns/1ps
module emb_mem_model
(
  input  wire logic        ale,
  input  wire logic        prog_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  lo,
  input  wire logic [7:0]  hi,
  output logic      [7:0]  drv,
  output logic      [15:0] addr
);
  logic [7:0] mem [65536];
  logic [7:0] last;
  ////////////////////////////////////////////////////////////////////////////
  // pattern fill so that unwritten places still answer known data
  initial
  begin
    last = 8'h00;
    addr = 16'h0000;
    for (int i = 0; i < 65536; i++)
      mem[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
  end
  // the latch closes on the falling edge of the strobe
  always @(negedge ale)
    addr = {hi, lo};
  // data written as the strobe rises, while the port still holds it
  always @(posedge wr_n)
    mem[addr] = lo;
  // remember the last driven byte so a released port never repeats it
  always @(posedge rd_n or posedge prog_n)
    last = mem[addr];
  // drive only while a read strobe is low, stale data inverted otherwise
  always @*
    drv = (!rd_n || !prog_n) ? mem[addr] : ~last;
endmodule

// file: external_memory_bus_interface_bench.sv
// self-checking bench of the external memory bus sequencer
`timescale 1ns/1ps
module external_memory_bus_interface_bench;
  import emb_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        req_valid, req_short, req_ready, resp_valid, resp_external;
  emb_kind_e   req_kind;
  logic [15:0] req_addr, mem_addr, a, e;
  logic [7:0]  req_wdata, resp_rdata, int_rdata, low_bus_port_in, low_bus_port_out;
  logic [7:0]  high_bus_port_out, mem_drv, page, d;
  logic        external_fetch_select_n, ale_in, ale_out, ale_oe, ale_s, prog_s;
  logic        program_read_strobe_n_in, program_read_strobe_n_out, program_read_strobe_n_oe;
  logic        write_strobe_n, read_strobe_n, strobe_oe, low_bus_port_oe, high_bus_port_oe;
  logic        err, s, bus_on, oe_seen;
  int          fail_count, n_tests, cycles;
  logic [7:0]  ref_mem [int];
  ////////////////////////////////////////////////////////////////////////////
  // pin levels: straps show only while the design lets go of the pin
  assign ale_in = ale_oe ? ale_out : ale_s;
  assign program_read_strobe_n_in = program_read_strobe_n_oe ? program_read_strobe_n_out : prog_s;
  assign low_bus_port_in = low_bus_port_oe ? low_bus_port_out : mem_drv;
  emb_ext_bus u_dut (.*);
  emb_mem_model u_mem
  (
    .ale    (ale_in),
    .prog_n (program_read_strobe_n_in),
    .rd_n   (strobe_oe ? read_strobe_n : 1'b1),
    .wr_n   (strobe_oe ? write_strobe_n : 1'b1),
    .lo     (low_bus_port_in),
    .hi     (high_bus_port_out),
    .drv    (mem_drv),
    .addr   (mem_addr)
  );
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // hang guard, runs far past the few hundred cycles needed
  always @(posedge pclk)
  begin
    cycles++;
    if (lo_oe_any())
      oe_seen = 1'b1;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end
  function automatic logic lo_oe_any();
    return low_bus_port_oe || high_bus_port_oe;
  endfunction
  // reference contents of external memory
  function automatic logic [7:0] ext_val(input logic [15:0] x);
    return ref_mem.exists(x) ? ref_mem[x] : x[7:0] ^ x[15:8] ^ 8'hA5;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // straps stand during reset; internal data is fresh for each run
  task automatic do_reset(input logic al, input logic pr, input logic ea);
    presetn <= 1'b0;
    ale_s <= al;
    prog_s <= pr;
    external_fetch_select_n <= ea;
    int_rdata <= 8'($urandom);
    bus_on = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    oe_seen = 1'b0;
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one core request; latched address is checked only with ports in bus use
  task automatic req(input emb_kind_e k, input logic sh, input logic [15:0] ad,
                     input logic [7:0] wd, input logic [7:0] xd, input logic xe,
                     input logic [15:0] xa);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_short <= sh;
    req_addr <= ad;
    req_wdata <= wd;
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do @(posedge pclk); while (resp_valid !== 1'b1);
    check(resp_rdata, xd, "data");
    check(resp_external, xe, "route");
    if (bus_on)
      check(mem_addr, xa, "latched address");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {presetn, psel, penable, pwrite, req_valid, req_short} = '0;
    {paddr, pwdata, req_addr, req_wdata, int_rdata} = '0;
    {ale_s, prog_s, external_fetch_select_n} = 3'b111;
    req_kind = KIND_FETCH;
    {fail_count, n_tests, cycles} = '0;
    void'($urandom(32'h18399349));
    // every strap code, each reset picks the mode again
    for (int m = 0; m < 4; m++)
    begin
      do_reset(m[0], m[1], 1'b1);
      apb(1'b0, IDX_STAT, 32'h0);
      check(rd[1:0], m[1:0], "mode");
    end
    // user mode: configuration locked, ports stay general-purpose
    apb(1'b1, IDX_CFG, 32'h0);
    apb(1'b0, IDX_CFG, 32'h0);
    check(rd, {24'h0, CFG_RESET}, "cfg lock");
    apb(1'b0, IDX_PAGE, 32'h0);
    check(rd, {24'h0, PAGE_RESET}, "page reset");
    apb(1'b1, IDX_STAT, 32'h0);
    check(err, 1'b1, "status write");
    apb(1'b0, 10'h3FF, 32'h0);
    check({err, rd}, {1'b1, 32'h0}, "unmapped");
    req(KIND_FETCH, 1'b0, 16'($urandom), 8'h00, int_rdata, 1'b0, 0);
    req(KIND_FETCH, 1'b0, 16'h7FFF, 8'h00, int_rdata, 1'b0, 0);
    req(KIND_FETCH, 1'b0, 16'h8000, 8'h00, 8'hFF, 1'b1, 0);
    a = 16'($urandom_range(16'hFFFF, 16'hF800));
    req(KIND_FETCH, 1'b0, a, 8'h00, int_rdata, 1'b0, 0);
    req(KIND_READ, 1'b0, 16'h0400, 8'h00, 8'hFF, 1'b1, 0);
    check(oe_seen, 1'b0, "gpio pins");
    // serial programming mode: open both ports to the bus
    do_reset(1'b1, 1'b0, 1'b1);
    page = 8'($urandom_range(255, 4));
    apb(1'b1, IDX_CFG, 32'h0);
    apb(1'b1, IDX_PAGE, {24'h0, page});
    apb(1'b0, IDX_CFG, 32'h0);
    check(rd, 32'h0, "cfg open");
    check(strobe_oe, 1'b1, "strobes driven");
    bus_on = 1'b1;
    req(KIND_FETCH, 1'b0, 16'($urandom), 8'h00, int_rdata, 1'b0, 16'h0000);
    a = 16'($urandom_range(16'h07FF, 16'h0001));
    req(KIND_FETCH, 1'b0, a, 8'h00, int_rdata, 1'b0, a);
    a = 16'($urandom_range(16'hFFFF, 16'h8000));
    req(KIND_FETCH, 1'b0, a, 8'h00, ext_val(a), 1'b1, a);
    for (int i = 0; i < 6; i++)
    begin
      s = i[0];
      a = 16'($urandom_range(16'hFFFF, 16'h0400));
      e = s ? {page, a[7:0]} : a;
      d = 8'($urandom);
      req(KIND_WRITE, s, a, d, 8'h00, 1'b1, e);
      ref_mem[e] = d;
      req(KIND_READ, s, a, 8'h00, ext_val(e), 1'b1, e);
    end
    a = 16'($urandom_range(16'h03FF, 16'h0000));
    req(KIND_READ, 1'b0, a, 8'h00, int_rdata, 1'b0, a);
    // strap low: every fetch goes out, boot addresses too
    do_reset(1'b1, 1'b1, 1'b0);
    apb(1'b0, IDX_CFG, 32'h0);
    check(rd, {24'h0, CFG_RESET}, "cfg back");
    req(KIND_FETCH, 1'b0, 16'($urandom), 8'h00, 8'hFF, 1'b1, 0);
    req(KIND_FETCH, 1'b0, 16'h0100, 8'h00, 8'hFF, 1'b1, 0);
    req(KIND_FETCH, 1'b0, 16'hF900, 8'h00, 8'hFF, 1'b1, 0);
    final_report();
  end
endmodule
